// ===== verilog/motion_interp_defs.svh
// constants for the serial motion command interpreter
// assumes byte-level reception is done elsewhere and delivered as valid-qualified bytes
`ifndef MOTION_INTERP_DEFS_SVH
`define MOTION_INTERP_DEFS_SVH

// ****************************************
// function codes and register addresses
// ****************************************
`define FC_WRITE_SINGLE    8'h06
`define FC_WRITE_MULTI     8'h10
`define ADDR_COMMAND_WORD  16'h001e
`define ADDR_TRAVEL_HI     16'h0402
`define ADDR_TRAVEL_LO     16'h0403
`define ADDR_SPEED_HI      16'h0502
`define ADDR_SPEED_LO      16'h0503

// ****************************************
// command word fields and reset values
// ****************************************
`define CMD_SLOT_SEL0_BIT  0
`define CMD_START_BIT      8
`define CMD_FORWARD_BIT    9
`define CMD_EXCITE_BIT     13
`define CMD_RESET_VALUE    16'h0000
`define SLOT_RESET_VALUE   32'h0000_0000

// ****************************************
// crc and link timing
// ****************************************
`define CRC_INIT           16'hffff
`define CRC_POLY           16'ha001
`define FRAME_GAP_NS       30000
`define FRAME_GAP_CYCLES   ((`FRAME_GAP_NS + 7) / 8)

`endif

// ===== verilog/motion_interp_pkg.sv
// types for the serial motion command interpreter
// assumes the defs header supplies all numeric constants
`default_nettype none
package motion_interp_pkg;
   // receive parser states
   typedef enum logic [3:0] {
      ST_SLAVE   = 4'b0000,
      ST_FUNC    = 4'b0001,
      ST_ADDR_HI = 4'b0010,
      ST_ADDR_LO = 4'b0011,
      ST_CNT_HI  = 4'b0100,
      ST_CNT_LO  = 4'b0101,
      ST_BYTES   = 4'b0110,
      ST_DATA    = 4'b0111,
      ST_CRC_LO  = 4'b1000,
      ST_CRC_HI  = 4'b1001,
      ST_SKIP    = 4'b1010
   } parse_state_type;

   // motion generator states
   typedef enum logic [1:0] {
      MO_IDLE     = 2'b00,
      MO_POSITION = 2'b01,
      MO_CONTINUE = 2'b10,
      MO_DECEL    = 2'b11
   } motion_state_type;
endpackage : motion_interp_pkg
`default_nettype wire

// ===== verilog/serial_motion_command_interp.sv
// serial motion command interpreter: parses register-write queries and runs the motion state
// assumes received bytes arrive one per rx_valid_in pulse, synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
`include "motion_interp_defs.svh"

module serial_motion_command_interp (
   input  wire logic        clk_in,          // 125 mhz system clock
   input  wire logic        reset_in,        // synchronous, active high
   input  wire logic [7:0]  rx_byte_in,      // received byte
   input  wire logic        rx_valid_in,     // one-cycle strobe per byte
   input  wire logic [7:0]  slave_addr_in,   // own station address
   input  wire logic        move_done_in,    // positioning finished
   input  wire logic        stopped_in,      // deceleration reached standstill
   output logic             excite_out,      // windings energised
   output logic             position_start_out, // one-cycle start pulse
   output logic             run_forward_out, // continuous forward run active
   output logic             decel_stop_out,  // decelerating to stop
   output logic             slot_select0_out,// selected slot bit 0
   output logic [31:0]      travel_out,      // slot 1 travel in steps
   output logic [31:0]      speed_out,       // slot 1 speed in hz
   output logic             query_ok_out,    // one-cycle: query committed
   output logic             query_bad_out    // one-cycle: crc mismatch
);

   // ****************************************
   // crc helper
   // ****************************************
   // one-byte crc16 update, reflected polynomial
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc_step

   // ****************************************
   // parser state
   // ****************************************
   motion_interp_pkg::parse_state_type state_q, state_d; // parser position
   logic [15:0] crc_q, crc_d;          // running check value
   logic [7:0]  func_q, func_d;        // function code
   logic [15:0] addr_q, addr_d;        // start register address
   logic [15:0] count_q, count_d;      // register count
   logic [2:0]  widx_q, widx_d;        // data byte index, max 8 bytes held
   logic [63:0] data_q, data_d;        // staged values, up to 4 registers
   logic [7:0]  crc_lo_q, crc_lo_d;    // received crc low byte
   logic        mine_q, mine_d;        // addressed to this station
   logic [12:0] gap_q, gap_d;          // idle counter for frame resync
   logic        commit;                // good query, apply writes
   logic        bad;                   // crc mismatch

   // ****************************************
   // register and motion state
   // ****************************************
   logic [15:0] cmd_q, cmd_d;          // motion command word
   logic [31:0] travel_q, travel_d;    // slot 1 travel
   logic [31:0] speed_q, speed_d;      // slot 1 speed
   motion_interp_pkg::motion_state_type mo_q, mo_d; // motion state
   logic        pstart_q, pstart_d;    // start pulse
   logic        ok_q, bad_q;           // query result pulses
   logic        run_q, run_d;          // forward run output flop
   logic        decel_q, decel_d;      // decelerating stop output flop

   // next-state for the byte parser
   always_comb begin
      state_d  = state_q;
      crc_d    = crc_q;
      func_d   = func_q;
      addr_d   = addr_q;
      count_d  = count_q;
      widx_d   = widx_q;
      data_d   = data_q;
      crc_lo_d = crc_lo_q;
      mine_d   = mine_q;
      commit   = 1'b0;
      bad      = 1'b0;
      // a silent line resynchronises to a new frame
      gap_d    = rx_valid_in ? 13'h0000 :
                 (gap_q == 13'(`FRAME_GAP_CYCLES)) ? gap_q : gap_q + 13'h0001;
      if (!rx_valid_in && gap_q == 13'(`FRAME_GAP_CYCLES - 1)) begin
         state_d = motion_interp_pkg::ST_SLAVE;
      end
      if (rx_valid_in) begin
         // crc runs over every byte before the check field
         if (state_q != motion_interp_pkg::ST_CRC_LO && state_q != motion_interp_pkg::ST_CRC_HI)
            crc_d = crc_step(crc_q, rx_byte_in);
         case (state_q)
            motion_interp_pkg::ST_SLAVE: begin
               crc_d   = crc_step(`CRC_INIT, rx_byte_in);
               mine_d  = (rx_byte_in == slave_addr_in);
               state_d = motion_interp_pkg::ST_FUNC;
            end
            motion_interp_pkg::ST_FUNC: begin
               func_d  = rx_byte_in;
               state_d = (rx_byte_in == `FC_WRITE_SINGLE || rx_byte_in == `FC_WRITE_MULTI) ?
                         motion_interp_pkg::ST_ADDR_HI : motion_interp_pkg::ST_SKIP;
            end
            motion_interp_pkg::ST_ADDR_HI: begin
               addr_d[15:8] = rx_byte_in;
               state_d = motion_interp_pkg::ST_ADDR_LO;
            end
            motion_interp_pkg::ST_ADDR_LO: begin
               addr_d[7:0] = rx_byte_in;
               widx_d = 3'd0;
               if (func_q == `FC_WRITE_SINGLE) begin
                  count_d = 16'h0001;
                  state_d = motion_interp_pkg::ST_DATA;
               end else begin
                  state_d = motion_interp_pkg::ST_CNT_HI;
               end
            end
            motion_interp_pkg::ST_CNT_HI: begin
               count_d[15:8] = rx_byte_in;
               state_d = motion_interp_pkg::ST_CNT_LO;
            end
            motion_interp_pkg::ST_CNT_LO: begin
               count_d[7:0] = rx_byte_in;
               state_d = motion_interp_pkg::ST_BYTES;
            end
            motion_interp_pkg::ST_BYTES: begin
               // byte count must be two per register, at most four registers held
               state_d = (rx_byte_in == {count_q[6:0], 1'b0} && count_q != 16'h0000 &&
                          count_q <= 16'h0004) ? motion_interp_pkg::ST_DATA :
                                                 motion_interp_pkg::ST_SKIP;
            end
            motion_interp_pkg::ST_DATA: begin
               // bytes shift in upper first
               data_d = {data_q[55:0], rx_byte_in};
               widx_d = widx_q + 3'd1;
               if ({13'h0000, widx_q} == {count_q[14:0], 1'b0} - 16'h0001)
                  state_d = motion_interp_pkg::ST_CRC_LO;
            end
            motion_interp_pkg::ST_CRC_LO: begin
               crc_lo_d = rx_byte_in;
               state_d  = motion_interp_pkg::ST_CRC_HI;
            end
            motion_interp_pkg::ST_CRC_HI: begin
               if ({rx_byte_in, crc_lo_q} == crc_q) commit = mine_q;
               else bad = 1'b1;
               state_d = motion_interp_pkg::ST_SLAVE;
            end
            motion_interp_pkg::ST_SKIP: begin
               // unsupported query: wait for line silence
               state_d = motion_interp_pkg::ST_SKIP;
            end
            default: state_d = motion_interp_pkg::ST_SLAVE;
         endcase
      end
   end

   // registers for the parser
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_q  <= motion_interp_pkg::ST_SLAVE;
         crc_q    <= `CRC_INIT;
         func_q   <= 8'h00;
         addr_q   <= 16'h0000;
         count_q  <= 16'h0000;
         widx_q   <= 3'd0;
         data_q   <= 64'h0;
         crc_lo_q <= 8'h00;
         mine_q   <= 1'b0;
         gap_q    <= 13'h0000;
      end else begin
         state_q  <= state_d;
         crc_q    <= crc_d;
         func_q   <= func_d;
         addr_q   <= addr_d;
         count_q  <= count_d;
         widx_q   <= widx_d;
         data_q   <= data_d;
         crc_lo_q <= crc_lo_d;
         mine_q   <= mine_d;
         gap_q    <= gap_d;
      end
   end

   // next values for holding registers and motion control
   always_comb begin
      logic [15:0] a;
      logic [15:0] v;
      logic [15:0] old_cmd;
      a        = 16'h0000;
      v        = 16'h0000;
      old_cmd  = cmd_q;
      cmd_d    = cmd_q;
      travel_d = travel_q;
      speed_d  = speed_q;
      if (commit) begin
         // writes are applied only after the check value matched
         for (int r = 0; r < 4; r++) begin
            if (16'(r) < count_q) begin
               a = addr_q + 16'(r);
               v = data_q[16*(32'(count_q) - 1 - r) +: 16];
               case (a)
                  `ADDR_COMMAND_WORD: cmd_d            = v;
                  `ADDR_TRAVEL_HI:    travel_d[31:16]  = v;
                  `ADDR_TRAVEL_LO:    travel_d[15:0]   = v;
                  `ADDR_SPEED_HI:     speed_d[31:16]   = v;
                  `ADDR_SPEED_LO:     speed_d[15:0]    = v;
                  default: ;          // other addresses ignored
               endcase
            end
         end
      end
      mo_d     = mo_q;
      pstart_d = 1'b0;
      case (mo_q)
         motion_interp_pkg::MO_IDLE: begin
            // only a rising start edge with excitation starts a move; release is no new move
            if (cmd_d[`CMD_EXCITE_BIT] && cmd_d[`CMD_START_BIT] &&
                !old_cmd[`CMD_START_BIT]) begin
               mo_d     = motion_interp_pkg::MO_POSITION;
               pstart_d = 1'b1;
            end else if (cmd_d[`CMD_EXCITE_BIT] && cmd_d[`CMD_FORWARD_BIT]) begin
               mo_d = motion_interp_pkg::MO_CONTINUE;
            end
         end
         motion_interp_pkg::MO_POSITION: begin
            if (!cmd_d[`CMD_EXCITE_BIT] || move_done_in) mo_d = motion_interp_pkg::MO_IDLE;
         end
         motion_interp_pkg::MO_CONTINUE: begin
            if (!cmd_d[`CMD_EXCITE_BIT]) mo_d = motion_interp_pkg::MO_IDLE;
            else if (!cmd_d[`CMD_FORWARD_BIT]) mo_d = motion_interp_pkg::MO_DECEL;
         end
         motion_interp_pkg::MO_DECEL: begin
            if (!cmd_d[`CMD_EXCITE_BIT] || stopped_in) mo_d = motion_interp_pkg::MO_IDLE;
         end
         default: mo_d = motion_interp_pkg::MO_IDLE;
      endcase
      // state decodes are registered so every port leaves a flip-flop, no glitching decode
      run_d   = (mo_d == motion_interp_pkg::MO_CONTINUE);
      decel_d = (mo_d == motion_interp_pkg::MO_DECEL);
   end

   // registers for command state and outputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cmd_q    <= `CMD_RESET_VALUE;
         travel_q <= `SLOT_RESET_VALUE;
         speed_q  <= `SLOT_RESET_VALUE;
         mo_q     <= motion_interp_pkg::MO_IDLE;
         pstart_q <= 1'b0;
         ok_q     <= 1'b0;
         bad_q    <= 1'b0;
         run_q    <= 1'b0;
         decel_q  <= 1'b0;
      end else begin
         cmd_q    <= cmd_d;
         travel_q <= travel_d;
         speed_q  <= speed_d;
         mo_q     <= mo_d;
         pstart_q <= pstart_d;
         ok_q     <= commit;
         bad_q    <= bad;
         run_q    <= run_d;
         decel_q  <= decel_d;
      end
   end

   // ****************************************
   // outputs, all from flip-flops
   // ****************************************
   assign excite_out         = cmd_q[`CMD_EXCITE_BIT];
   assign slot_select0_out   = cmd_q[`CMD_SLOT_SEL0_BIT];
   assign position_start_out = pstart_q;
   assign run_forward_out    = run_q;
   assign decel_stop_out     = decel_q;
   assign travel_out         = travel_q;
   assign speed_out          = speed_q;
   assign query_ok_out       = ok_q;
   assign query_bad_out      = bad_q;

endmodule : serial_motion_command_interp
`default_nettype wire

// ===== tb/serial_motion_command_interp_chk.sv
// checker: port-level timing relations of the command interpreter
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module serial_motion_command_interp_chk (
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic [7:0]  rx_byte_in,
   input wire logic        rx_valid_in,
   input wire logic [7:0]  slave_addr_in,
   input wire logic        move_done_in,
   input wire logic        stopped_in,
   input wire logic        excite_out,
   input wire logic        position_start_out,
   input wire logic        run_forward_out,
   input wire logic        decel_stop_out,
   input wire logic        slot_select0_out,
   input wire logic [31:0] travel_out,
   input wire logic [31:0] speed_out,
   input wire logic        query_ok_out,
   input wire logic        query_bad_out
);
   // one clock domain, so clocking and disable are given once
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // a start is one pulse, raised only by a committed query on an excited motor
   AST_START_ONE_CYCLE: assert property (position_start_out |=> !position_start_out)
      else $error("start pulse longer than one cycle");
   AST_START_NEEDS_QUERY: assert property (
      position_start_out |-> query_ok_out && excite_out && slot_select0_out)
      else $error("start without committed excited query");
   AST_EXCITE_BY_QUERY: assert property ($changed(excite_out) |-> query_ok_out)
      else $error("excitation changed without a query");
   AST_RUN_EXCITED: assert property (run_forward_out |-> excite_out && slot_select0_out)
      else $error("forward run while not excited");
   AST_RUN_BY_QUERY: assert property ($rose(run_forward_out) |-> query_ok_out)
      else $error("forward run began without a query");
   // leaving the run with windings on must pass through a decelerating stop
   AST_DECEL_AFTER_RUN: assert property (
      $fell(run_forward_out) && excite_out |-> decel_stop_out)
      else $error("run ended without deceleration");
   AST_DECEL_EXCITED: assert property (decel_stop_out |-> excite_out && !run_forward_out)
      else $error("deceleration lost excitation");
   AST_TRAVEL_BY_QUERY: assert property ($changed(travel_out) |-> query_ok_out)
      else $error("travel changed without a query");
   AST_SPEED_BY_QUERY: assert property ($changed(speed_out) |-> query_ok_out)
      else $error("speed changed without a query");
   AST_BAD_NO_WRITE: assert property (
      query_bad_out |-> !query_ok_out && $stable(travel_out) && $stable(speed_out))
      else $error("corrupt query was committed");
endmodule : serial_motion_command_interp_chk

bind serial_motion_command_interp serial_motion_command_interp_chk chk_u (
   .clk_in(clk_in), .reset_in(reset_in), .rx_byte_in(rx_byte_in), .rx_valid_in(rx_valid_in),
   .slave_addr_in(slave_addr_in), .move_done_in(move_done_in), .stopped_in(stopped_in),
   .excite_out(excite_out), .position_start_out(position_start_out),
   .run_forward_out(run_forward_out), .decel_stop_out(decel_stop_out),
   .slot_select0_out(slot_select0_out), .travel_out(travel_out), .speed_out(speed_out),
   .query_ok_out(query_ok_out), .query_bad_out(query_bad_out));
`default_nettype wire

// ===== tb/serial_master_model.sv
// model of the bus master: sends write queries byte by byte with a trailing check value
// assumes the interpreter takes one byte per valid strobe on clk_in
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// master model
// ****************************************
module serial_master_model (
   input  wire logic       clk_in,       // system clock
   output logic      [7:0] rx_byte_out,  // byte toward the interpreter
   output logic            rx_valid_out  // one strobe per byte
);
   initial begin
      rx_byte_out  = 8'h00;
      rx_valid_out = 1'b0;
   end
   // crc-16, reflected form, over all bytes before the check value
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction : crc16
   // bad flips one check bit so the query must be discarded
   task automatic send_query(input logic [7:0] q[$], input logic bad);
      logic [7:0]  lq[$];
      logic [15:0] c;
      lq = q;
      c = crc16(lq) ^ {15'h0000, bad};
      lq.push_back(c[7:0]);
      lq.push_back(c[15:8]);
      foreach (lq[i]) begin
         @(posedge clk_in);
         rx_byte_out  <= lq[i];
         rx_valid_out <= 1'b1;
      end
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_byte_out  <= ~rx_byte_out; // idle line never repeats the last byte
   endtask : send_query
endmodule : serial_master_model
`default_nettype wire

// ===== tb/serial_motion_command_interp_tb.sv
// testbench: positioning, continuous run and faulty queries through the serial port
// assumes the master model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// testbench top
// ****************************************
module serial_motion_command_interp_tb;
   logic        clk_in = 1'b0;    // 125 mhz
   logic        reset_in = 1'b1;  // held for four cycles
   logic        move_done_in = 1'b0;
   logic        stopped_in = 1'b0;
   logic [7:0]  rx_byte;
   logic        rx_valid;
   logic        excite, start, run_fwd, decel, slot0, q_ok, q_bad;
   logic [31:0] travel, speed;
   int          num_errors = 0, checked = 0, n_start = 0, n_bad = 0, n_ok = 0, cycles = 0;
   always #4 clk_in = ~clk_in;
   serial_master_model master_u (.clk_in(clk_in), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid));
   serial_motion_command_interp dut_u (.clk_in(clk_in), .reset_in(reset_in),
      .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .slave_addr_in(8'h01),
      .move_done_in(move_done_in), .stopped_in(stopped_in), .excite_out(excite),
      .position_start_out(start), .run_forward_out(run_fwd), .decel_stop_out(decel),
      .slot_select0_out(slot0), .travel_out(travel), .speed_out(speed),
      .query_ok_out(q_ok), .query_bad_out(q_bad));
   // pulse counters, so single-cycle outputs are never missed; also the hang limit
   always @(posedge clk_in) begin
      if (start === 1'b1) n_start++;
      if (q_bad === 1'b1) n_bad++;
      if (q_ok === 1'b1) n_ok++;
      cycles++;
      // tests need about 4000 cycles, most of it the silent gap of the refused query
      if (cycles == 6000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic check_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: flag mismatch", $time);
      end
   endtask : check_bit
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : check_word
   // single register write; upper byte of address and value first
   task automatic wr1(input logic [7:0] st, input logic [15:0] a, input logic [15:0] v);
      logic [7:0] q[$];
      q = '{st, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]};
      master_u.send_query(q, 1'b0);
      repeat (3) @(posedge clk_in);
   endtask : wr1
   // two-register write of a 32-bit value, upper word at the address
   task automatic wrm(input logic [15:0] a, input logic [31:0] v, input logic bad);
      logic [7:0] q[$];
      q = '{8'h01, 8'h10, a[15:8], a[7:0], 8'h00, 8'h02, 8'h04,
            v[31:24], v[23:16], v[15:8], v[7:0]};
      master_u.send_query(q, bad);
      repeat (3) @(posedge clk_in);
   endtask : wrm
   task automatic test_position;
      int s0;
      check_word(travel, 32'h0000_0000);
      wr1(8'h01, 16'h001e, 16'h2000);
      check_bit(excite, 1'b1);
      wrm(16'h0402, 32'h0000_03e8, 1'b0);
      check_word(travel, 32'h0000_03e8);
      wrm(16'h0502, 32'h0000_1388, 1'b0);
      check_word(speed, 32'h0000_1388);
      s0 = n_start;
      wr1(8'h01, 16'h001e, 16'h2101);
      check_word(32'(n_start - s0), 32'h1);
      check_bit(slot0, 1'b1);
      wr1(8'h01, 16'h001e, 16'h2001);
      check_word(32'(n_start - s0), 32'h1);
      move_done_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      move_done_in <= 1'b0;
      $display("test_position done");
   endtask : test_position
   task automatic test_continuous;
      wr1(8'h01, 16'h001e, 16'h2201);
      check_bit(run_fwd, 1'b1);
      check_word(speed, 32'h0000_1388);
      wr1(8'h01, 16'h001e, 16'h2001);
      check_bit(run_fwd, 1'b0);
      check_bit(decel, 1'b1);
      check_bit(excite, 1'b1);
      stopped_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      check_bit(decel, 1'b0);
      stopped_in <= 1'b0;
      $display("test_continuous done");
   endtask : test_continuous
   task automatic test_faults;
      int b0;
      int k0;
      b0 = n_bad;
      k0 = n_ok;
      wrm(16'h0402, 32'h0001_0000, 1'b1);
      check_word(travel, 32'h0000_03e8);
      check_word(32'(n_bad - b0), 32'h1);
      wr1(8'h02, 16'h001e, 16'h0000);
      check_bit(excite, 1'b1);
      check_word(32'(n_ok - k0), 32'h0);
      wr1(8'h01, 16'h0503, 16'h0010);
      check_word(speed, 32'h0000_0010);
      check_word(32'(n_ok - k0), 32'h1);
      wr1(8'h01, 16'h001e, 16'h0000);
      check_bit(excite, 1'b0);
      $display("test_faults done");
   endtask : test_faults
   // a byte count that is not two per register skips the frame until the line falls silent
   task automatic test_refused;
      logic [7:0] q[$];
      int         k0;
      int         b0;
      k0 = n_ok;
      b0 = n_bad;
      q = '{8'h01, 8'h10, 8'h04, 8'h02, 8'h00, 8'h02, 8'h03, 8'h00, 8'h07, 8'h00};
      master_u.send_query(q, 1'b0);
      repeat (3) @(posedge clk_in);
      check_word(32'(n_ok - k0), 32'h0);
      check_word(32'(n_bad - b0), 32'h0);
      check_word(travel, 32'h0000_03e8);
      // wait past the resync gap, else the next query would be swallowed too
      repeat (3760) @(posedge clk_in);
      wr1(8'h01, 16'h001e, 16'h2000);
      check_word(32'(n_ok - k0), 32'h1);
      check_bit(excite, 1'b1);
      $display("test_refused done");
   endtask : test_refused
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      test_position();
      test_continuous();
      test_faults();
      test_refused();
      tally_and_finish();
   end
endmodule : serial_motion_command_interp_tb
`default_nettype wire
